// file: include/nv_access_consts.vh
// Constants for the nonvolatile data store access controller.
`ifndef NV_ACCESS_CONSTS_VH
`define NV_ACCESS_CONSTS_VH
`define IO_DATA_OFFSET 8'h20
`define BIT_IO_LIMIT 8'h1F
`define ADDR_LOW_IO 8'h1E
`define ADDR_HIGH_IO 8'h1F
`define DATA_BYTE_IO 8'h1D
`define CONTROL_IO 8'h1C
`define CTL_READ_STROBE 0
`define CTL_PROGRAM_ENABLE 1
`define CTL_MASTER_ARM 2
`define CTL_READY_IE 3
`define CTL_MODE_LO 4
`define CTL_MODE_HI 5
`define MODE_ATOMIC 2'h0
`define MODE_ERASE 2'h1
`define MODE_WRITE 2'h2
`define MODE_RESERVED 2'h3
`define ATOMIC_TIME_NS 3400000
`define SPLIT_TIME_NS 1800000
`define CLK_PERIOD_NS 40
`define ARM_WINDOW_CYCLES 3'h4
`define READ_STALL_CYCLES 3'h4
`define PROGRAM_STALL_CYCLES 3'h2
`define ERASED_BYTE 8'hFF
`endif

// file: rtl/nv_access_controller.v
// Register access controller for on-chip nonvolatile data bytes.
//
// Operation
// RULE_01: A running erase or write completes even when reset is asserted.
// RULE_02: Registers at I/O 0x00-0x1F support single-bit set, clear and test.
// RULE_03: Each register decodes at its I/O address and at address plus 0x20.
// RULE_04: High address register bits 7:1 read as zero.
// RULE_05: Only needed address bits exist; unused top bits read zero.
// RULE_06: The address register has no defined reset value.
// RULE_07: Bytes are addressed linearly from zero, low register giving low bits.
// RULE_08: Data register is programming source and receives read bytes.
// RULE_09: Control bits 7 and 6 read zero; software writes bit 7 zero.
// RULE_10: Mode 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms.
// RULE_11: Mode field writes are ignored while program enable is set.
// RULE_12: Reset clears the mode field unless programming is in progress.
// RULE_13: Ready interrupt needs its enable bit and the global enable.
// RULE_14: Ready interrupt is a level while the store is idle.
// RULE_15: Program enable starts only within four cycles after master arm.
// RULE_16: Master arm clears itself four cycles after being written one.
// RULE_17: The trigger performs the selected mode on the addressed byte.
// RULE_18: Program enable stays set until the mode's time has elapsed.
// RULE_19: Setting program enable stalls the processor for two cycles.
// RULE_20: Core reads by waiting idle, loading address, strobing, taking data.
// RULE_21: Core writes by setting mode, address, data, arm, then enable.
// RULE_22: Read strobe loads the byte at once and stalls four cycles.
// RULE_23: While programming, read strobes and address writes are ignored.
// RULE_24: Programming time comes from the calibrated timing clock; the code counts cycles of clk instead.
// RULE_25: A scaled cycle counter times each mode before completion.
`timescale 1ns/1ps
`include "nv_access_consts.vh"

module nv_access_controller #(
    parameter ADDR_BITS = 9,
    parameter ATOMIC_CYCLES = `ATOMIC_TIME_NS / `CLK_PERIOD_NS,
    parameter SPLIT_CYCLES = `SPLIT_TIME_NS / `CLK_PERIOD_NS
) (
    input wire clk,
    input wire reset,
    input wire [7:0] io_addr,
    input wire data_space,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] wr_data,
    input wire bit_set,
    input wire bit_clear,
    input wire bit_test,
    input wire [2:0] bit_sel,
    input wire global_int_enable,
    output reg [7:0] rd_data,
    output reg bit_value,
    output reg core_stall,
    output reg ready_irq,
    output reg busy
);

    localparam ST_IDLE = 2'b00;
    localparam ST_PROGRAM = 2'b01;
    localparam DEPTH = 1 << ADDR_BITS;

    // Maps a data-space address back into the I/O space.
    function [7:0] io_index;
        input [7:0] a;
        input ds;
        begin
            io_index = ds ? a - `IO_DATA_OFFSET : a;
        end
    endfunction

    reg [7:0] store [0:DEPTH-1];
    reg [ADDR_BITS-1:0] addr_q;
    reg [7:0] data_q;
    reg [1:0] mode_q;
    reg ready_ie_q;
    reg arm_q;
    reg [2:0] arm_cnt_q;
    reg prog_q;
    reg [1:0] state_q;
    reg [1:0] op_mode_q;
    reg [ADDR_BITS-1:0] op_addr_q;
    reg [7:0] op_data_q;
    reg [31:0] timer_q;
    reg [2:0] stall_q;
    reg [7:0] ctl_rd;
    reg [7:0] idx;
    reg [7:0] wval;
    reg hit_lo;
    reg hit_hi;
    reg hit_dat;
    reg hit_ctl;
    reg access_ok;
    reg [7:0] cur;
    reg [7:0] rbyte;
    wire [15:0] addr_wide;
    wire start_prog;

    assign addr_wide = {{(16 - ADDR_BITS){1'b0}}, addr_q};

    ///////////////////////////////////////////////////////////////////////
    // Address decode and write value merge for bit operations.
    always @* begin
        idx = io_index(io_addr, data_space); // RULE_03
        hit_lo = idx == `ADDR_LOW_IO;
        hit_hi = idx == `ADDR_HIGH_IO;
        hit_dat = idx == `DATA_BYTE_IO;
        hit_ctl = idx == `CONTROL_IO;
        access_ok = (data_space ? io_addr >= `IO_DATA_OFFSET : 1'b1);
        ctl_rd = 8'h00; // RULE_09
        ctl_rd[`CTL_MODE_HI] = mode_q[1];
        ctl_rd[`CTL_MODE_LO] = mode_q[0];
        ctl_rd[`CTL_READY_IE] = ready_ie_q;
        ctl_rd[`CTL_MASTER_ARM] = arm_q;
        ctl_rd[`CTL_PROGRAM_ENABLE] = prog_q;
        cur = 8'h00;
        if (hit_lo) begin
            cur = addr_wide[7:0]; // RULE_05
        end else if (hit_hi) begin
            cur = {7'h00, addr_wide[8]}; // RULE_04
        end else if (hit_dat) begin
            cur = data_q;
        end else if (hit_ctl) begin
            cur = ctl_rd;
        end
        // Bit operations touch only the named bit; others keep their value.
        wval = wr_data;
        if (bit_set || bit_clear) begin
            wval = cur; // RULE_02
            wval[bit_sel] = bit_set;
        end
        rbyte = store[addr_q]; // RULE_07
    end

    // A one written to program enable only counts while arm is live.
    assign start_prog = access_ok && hit_ctl && (wr_en || bit_set)
        && wval[`CTL_PROGRAM_ENABLE] && arm_q && !prog_q; // RULE_15

    ///////////////////////////////////////////////////////////////////////
    // Address and data registers; no reset so the address stays undefined.
    always @(posedge clk) begin
        if (access_ok && (wr_en || bit_set || bit_clear) && !prog_q) begin
            if (hit_lo) begin
                addr_q[7:0] <= wval[7:0]; // RULE_23
            end
            if (hit_hi && ADDR_BITS > 8) begin
                addr_q[ADDR_BITS-1] <= wval[0]; // RULE_06
            end
        end
        if (access_ok && hit_ctl && (wr_en || bit_set)
            && wval[`CTL_READ_STROBE] && !prog_q) begin
            data_q <= rbyte; // RULE_22
        end else if (access_ok && hit_dat && (wr_en || bit_set || bit_clear))
        begin
            data_q <= wval; // RULE_08
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Array update at the end of an operation, using latched operands.
    always @(posedge clk) begin
        if (state_q == ST_PROGRAM && timer_q == 32'h00000001) begin
            case (op_mode_q) // RULE_17
                `MODE_ATOMIC: store[op_addr_q] <= op_data_q;
                `MODE_ERASE: store[op_addr_q] <= `ERASED_BYTE;
                `MODE_WRITE: store[op_addr_q] <= store[op_addr_q] & op_data_q;
                default: store[op_addr_q] <= store[op_addr_q];
            endcase
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Programming engine. Reset never aborts a running operation, since a
    // half-finished cell would hold garbage.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            // Constant-only reset; the running operation keeps its state.
            ready_ie_q <= 1'b0;
            arm_q <= 1'b0;
            arm_cnt_q <= 3'h0;
            stall_q <= 3'h0;
        end else begin
            if (arm_q) begin
                if (arm_cnt_q == `ARM_WINDOW_CYCLES - 3'h1) begin
                    arm_q <= 1'b0; // RULE_16
                end
                arm_cnt_q <= arm_cnt_q + 3'h1;
            end
            if (access_ok && hit_ctl && (wr_en || bit_set || bit_clear)) begin
                ready_ie_q <= wval[`CTL_READY_IE]; // RULE_13
                if (wval[`CTL_MASTER_ARM] && !ctl_rd[`CTL_MASTER_ARM]) begin
                    arm_q <= 1'b1;
                    arm_cnt_q <= 3'h0;
                end
            end
            if (start_prog) begin
                stall_q <= `PROGRAM_STALL_CYCLES; // RULE_19
            end else if (access_ok && hit_ctl && (wr_en || bit_set)
                && wval[`CTL_READ_STROBE] && !prog_q) begin
                stall_q <= `READ_STALL_CYCLES; // RULE_22
            end else if (stall_q != 3'h0) begin
                stall_q <= stall_q - 3'h1;
            end
        end
    end

    // Operation state survives reset; only an idle engine takes the mode
    // field back to zero.
    always @(posedge clk) begin
        if (reset) begin
            // Test for a running operation first, so that an unknown state
            // at power-up falls into the idle branch and is cleared.
            if (state_q == ST_PROGRAM) begin
                timer_q <= timer_q - 32'h00000001; // RULE_01
                if (timer_q == 32'h00000001) begin
                    state_q <= ST_IDLE;
                    prog_q <= 1'b0;
                end
            end else begin
                mode_q <= `MODE_ATOMIC; // RULE_12
                state_q <= ST_IDLE;
                prog_q <= 1'b0;
                timer_q <= 32'h00000000;
            end
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (access_ok && hit_ctl
                        && (wr_en || bit_set || bit_clear)) begin
                        mode_q <= {wval[`CTL_MODE_HI], wval[`CTL_MODE_LO]};
                    end
                    if (start_prog
                        && mode_q != `MODE_RESERVED) begin
                        prog_q <= 1'b1;
                        state_q <= ST_PROGRAM;
                        op_mode_q <= mode_q;
                        op_addr_q <= addr_q;
                        op_data_q <= data_q;
                        // Counter scaled to the clk period. RULE_24
                        timer_q <= (mode_q == `MODE_ATOMIC) ?
                            ATOMIC_CYCLES : SPLIT_CYCLES; // RULE_10 RULE_25
                    end
                end
                ST_PROGRAM: begin
                    // Mode writes ignored while busy. RULE_11
                    timer_q <= timer_q - 32'h00000001;
                    if (timer_q == 32'h00000001) begin
                        prog_q <= 1'b0; // RULE_18
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    prog_q <= 1'b0;
                end
            endcase
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Registered outputs toward the core.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data <= 8'h00;
            bit_value <= 1'b0;
            core_stall <= 1'b0;
            ready_irq <= 1'b0;
            busy <= 1'b0;
        end else begin
            rd_data <= (access_ok && rd_en) ? cur : 8'h00;
            bit_value <= bit_test && idx <= `BIT_IO_LIMIT
                && cur[bit_sel]; // RULE_02
            core_stall <= start_prog || (stall_q > 3'h1)
                || (access_ok && hit_ctl && (wr_en || bit_set)
                && wval[`CTL_READ_STROBE] && !prog_q);
            ready_irq <= ready_ie_q && global_int_enable
                && !prog_q; // RULE_13 RULE_14
            busy <= prog_q;
        end
    end

endmodule

// file: bench/nv_access_chk.sv
// Port checker for the nonvolatile access controller.
`timescale 1ns/1ps
module nv_access_chk #(
    parameter ATOMIC_CYCLES = 20
) (
    input wire clk,
    input wire reset,
    input wire [7:0] io_addr,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] wr_data,
    input wire bit_set,
    input wire [2:0] bit_sel,
    input wire global_int_enable,
    input wire [7:0] rd_data,
    input wire core_stall,
    input wire ready_irq,
    input wire busy
);
    // Control decode covers both the I/O and the data-space alias.
    wire ctl = (io_addr & 8'hDF) == 8'h1C;
    wire arm = ctl && (wr_en && wr_data[2] || bit_set && bit_sel == 3'h2);
    wire strobe = ctl && !busy && (wr_en && wr_data[0] ||
        bit_set && bit_sel == 3'h0);
    reg [3:0] age_q;
    reg [19:0] len_q;
    // Length is held through reset, since a running program survives it.
    always @(posedge clk) begin
        age_q <= arm ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
        len_q <= busy ? len_q + 20'h1 : (reset ? len_q : 20'h0);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    stall_prog_a: assert property (
        $rose(busy) && !$past(reset, 2) |-> $past(core_stall) && core_stall
        ##1 !core_stall) else $error("program stall length wrong");
    stall_read_a: assert property (
        strobe |=> core_stall [*4] ##1 !core_stall)
        else $error("read stall length wrong");
    arm_window_a: assert property (
        $rose(busy) && !$past(reset, 2) |-> age_q <= 4'h5)
        else $error("program started without a recent arm");
    irq_busy_a: assert property (
        busy && $past(busy) |-> !ready_irq) else $error("irq while busy");
    irq_gie_a: assert property (
        !global_int_enable && !$past(global_int_enable) |-> !ready_irq)
        else $error("irq without global enable");
    ctl_res_a: assert property (
        $past(rd_en && ctl) |-> rd_data[7:6] == 2'h0)
        else $error("control top bits not zero");
    hi_zero_a: assert property (
        $past(rd_en && (io_addr & 8'hDF) == 8'h1F) |-> rd_data[7:1] == 7'h00)
        else $error("high address top bits not zero");
    busy_len_a: assert property (
        $fell(busy) |-> len_q <= ATOMIC_CYCLES + 2)
        else $error("program ran too long");
    cover property ($rose(busy));
    cover property (strobe);
    cover property (ready_irq);
endmodule
bind nv_access_controller nv_access_chk #(.ATOMIC_CYCLES(ATOMIC_CYCLES)) u_chk (
    .clk(clk), .reset(reset), .io_addr(io_addr), .wr_en(wr_en),
    .rd_en(rd_en), .wr_data(wr_data), .bit_set(bit_set), .bit_sel(bit_sel),
    .global_int_enable(global_int_enable), .rd_data(rd_data),
    .core_stall(core_stall), .ready_irq(ready_irq), .busy(busy));

// file: bench/core_model.sv
// Behavioural processor core issuing register accesses.
`timescale 1ns/1ps
`include "nv_access_consts.vh"
module core_model (
    input wire clk,
    input wire core_stall,
    input wire busy,
    input wire [7:0] rd_data,
    input wire bit_value,
    output reg [7:0] io_addr,
    output reg data_space,
    output reg [4:0] req,
    output reg [7:0] wr_data,
    output reg [2:0] bit_sel
);
    integer w;
    initial begin
        {io_addr, data_space, req, wr_data, bit_sel} = 25'h0000000;
    end
    // One access, k = {test, clear, set, read, write}; never while halted.
    task op(input [4:0] k, input [7:0] a, input [7:0] d, output [7:0] q);
        integer n;
        begin
            n = 0;
            while (core_stall !== 1'b0 && n < 20) begin
                @(negedge clk);
                n = n + 1;
            end
            if (n >= 20) tb_top.chk(8'h01, 8'h00);
            if (n >= 20) tb_top.end_of_test;
            req = k;
            io_addr = a;
            data_space = a > 8'h1F;
            wr_data = d;
            bit_sel = d[2:0];
            @(negedge clk);
            q = k[4] ? {7'h00, bit_value} : rd_data;
            req = 5'h00;
            @(negedge clk);
        end
    endtask
    // Bounded poll of the program enable mirror.
    task wait_idle(output integer c);
        begin
            c = 0;
            while (busy !== 1'b0 && c < 100) begin
                @(negedge clk);
                c = c + 1;
            end
            if (c >= 100) tb_top.chk(8'h01, 8'h00);
            if (c >= 100) tb_top.end_of_test;
        end
    endtask
    // Mode with ready enable, address, data, arm, then trigger.
    task prog(input [1:0] m, input [8:0] a, input [7:0] d);
        reg [7:0] x;
        begin
            wait_idle(w);
            op(5'h01, `CONTROL_IO, {2'h0, m, 4'h8}, x);
            op(5'h01, `ADDR_HIGH_IO, {7'h00, a[8]}, x);
            op(5'h01, `ADDR_LOW_IO, a[7:0], x);
            op(5'h01, `DATA_BYTE_IO, d, x);
            op(5'h04, `CONTROL_IO, 8'h02, x);
            op(5'h04, `CONTROL_IO, 8'h01, x);
        end
    endtask
    // Read one byte; the low address goes through the data-space alias.
    task rb(input [8:0] a, output [7:0] q);
        begin
            wait_idle(w);
            op(5'h01, `ADDR_HIGH_IO, {7'h00, a[8]}, q);
            op(5'h01, `ADDR_LOW_IO + `IO_DATA_OFFSET, a[7:0], q);
            op(5'h04, `CONTROL_IO, 8'h00, q);
            op(5'h02, `DATA_BYTE_IO, 8'h00, q);
        end
    endtask
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the nonvolatile access controller.
`timescale 1ns/1ps
`include "nv_access_consts.vh"
module tb_top;
    localparam AT = 20;
    localparam SP = 10;
    localparam [31:0] DIN = 32'h113C005A;
    localparam [31:0] EXP = 32'h3C3CFF5A;
    reg clk = 1'b0;
    reg reset = 1'b1;
    reg gie = 1'b0;
    wire [7:0] io_addr, wr_data, rd_data;
    wire [4:0] req;
    wire [2:0] bit_sel;
    wire data_space, bit_value, core_stall, ready_irq, busy;
    integer fail_count = 0;
    integer samples_checked = 0;
    integer i;
    integer n;
    reg [7:0] q;
    initial begin
        forever #20 clk = ~clk;
    end
    // Short program times keep the run brief.
    nv_access_controller #(.ADDR_BITS(9), .ATOMIC_CYCLES(AT),
        .SPLIT_CYCLES(SP)) i_nv_access_controller (
        .clk(clk), .reset(reset), .io_addr(io_addr),
        .data_space(data_space), .wr_en(req[0]), .rd_en(req[1]),
        .wr_data(wr_data), .bit_set(req[2]), .bit_clear(req[3]),
        .bit_test(req[4]), .bit_sel(bit_sel), .global_int_enable(gie),
        .rd_data(rd_data), .bit_value(bit_value), .core_stall(core_stall),
        .ready_irq(ready_irq), .busy(busy));
    core_model core (.clk(clk), .core_stall(core_stall), .busy(busy),
        .rd_data(rd_data), .bit_value(bit_value), .io_addr(io_addr),
        .data_space(data_space), .req(req), .wr_data(wr_data),
        .bit_sel(bit_sel));
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        core.op(5'h02, `CONTROL_IO, 8'h00, q);
        chk(q, 8'h00);
        core.op(5'h01, `ADDR_HIGH_IO, 8'hFF, q);
        core.op(5'h02, `ADDR_HIGH_IO + `IO_DATA_OFFSET, 8'h00, q);
        chk(q, 8'h01);
        // Atomic, erase, write and the reserved mode on one byte.
        for (i = 0; i < 4; i = i + 1) begin
            core.prog(i[1:0], 9'h105, DIN[8*i +: 8]);
            core.wait_idle(n);
            n = n - (i == 0 ? AT : (i == 3 ? 0 : SP));
            chk({7'h00, n >= -4 && n <= 0}, 8'h01);
            core.rb(9'h105, q);
            chk(q, EXP[8*i +: 8]);
        end
        // Ready enable is left on; the request shows once global is set.
        gie = 1'b1;
        @(negedge clk);
        chk({7'h00, ready_irq}, 8'h01);
        // Address and mode writes are dropped while programming.
        core.prog(2'h0, 9'h105, 8'h77);
        core.op(5'h01, `ADDR_LOW_IO, 8'hAA, q);
        chk({7'h00, ready_irq}, 8'h00);
        core.op(5'h01, `CONTROL_IO, 8'h20, q);
        core.op(5'h02, `CONTROL_IO, 8'h00, q);
        chk(q, 8'h02);
        core.wait_idle(n);
        core.op(5'h01, `DATA_BYTE_IO, 8'h00, q);
        core.op(5'h04, `CONTROL_IO, 8'h00, q);
        core.op(5'h02, `DATA_BYTE_IO, 8'h00, q);
        chk(q, 8'h77);
        // Trigger without arm, then after the arm has lapsed.
        core.op(5'h01, `CONTROL_IO, 8'h02, q);
        core.op(5'h01, `CONTROL_IO, 8'h04, q);
        repeat (4) @(negedge clk);
        core.op(5'h04, `CONTROL_IO, 8'h01, q);
        core.op(5'h04, `CONTROL_IO, 8'h03, q);
        core.op(5'h10, `CONTROL_IO, 8'h03, q);
        chk(q, 8'h01);
        chk({7'h00, ready_irq}, 8'h01);
        core.op(5'h02, `CONTROL_IO, 8'h00, q);
        chk(q, 8'h08);
        core.op(5'h08, `CONTROL_IO, 8'h03, q);
        chk({7'h00, ready_irq}, 8'h00);
        // A reset in mid-program must not stop it or clear its mode.
        core.prog(2'h2, 9'h105, 8'h99);
        reset = 1'b1;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        core.op(5'h02, `CONTROL_IO, 8'h00, q);
        chk(q, 8'h22);
        core.rb(9'h105, q);
        chk(q, 8'h11);
        end_of_test;
    end
endmodule
